// ==== pfs_fault_regs.sv ====
// Fault status register bank with APB slave and interrupt output
// Summary of operation
// - Rail fault bit 4 records loss of regulation on the first adjustable LDO, bit 3 on the termination LDO.
// - Rail fault bits 2 and 1 record the second and first B-group switchers, bit 0 the third LDO.
// - A rail fault flag stays set until the host writes one to its bit.
// - The critical temperature register sits at index b4h and resets to zero.
// - Five sensors map to critical bits 4 die rest, 3 termination, 2 upper right, 1 upper left, 0 lower right.
// - Corner positions are seen from the die top with pin one at the upper left.
// - Temperature bits 7 to 5 read zero and ignore writes; bits 4 to 0 are write-one-to-clear.
// - The hot temperature register sits at index b5h and resets to zero.
// - Hot bits use the same sensor mapping as the critical register.
// - Every temperature flag stays set until the host writes one to its bit.
// - The overcurrent register sits at index b6h and resets to zero.
// - Overcurrent bits 2, 1, 0 record controllers six, two, one; bits 7 to 3 read zero.
`timescale 1ns/100ps
`default_nettype none
module pfs_fault_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ldo_a_one_fault,
  input  wire logic        termination_ldo_fault,
  input  wire logic        switcher_b_two_fault,
  input  wire logic        switcher_b_one_fault,
  input  wire logic        ldo_a_three_fault,
  input  wire logic        die_rest_critical,
  input  wire logic        termination_critical,
  input  wire logic        upper_right_critical,
  input  wire logic        upper_left_critical,
  input  wire logic        lower_right_critical,
  input  wire logic        die_rest_overheat,
  input  wire logic        termination_overheat,
  input  wire logic        upper_right_overheat,
  input  wire logic        upper_left_overheat,
  input  wire logic        lower_right_overheat,
  input  wire logic        controller_six_overcurrent,
  input  wire logic        controller_two_overcurrent,
  input  wire logic        controller_one_overcurrent,
  output logic             irq
);
  localparam int RW = pfs_pkg::rail_width;
  localparam int TW = pfs_pkg::temp_width;
  localparam int OW = pfs_pkg::oc_width;
  localparam int IW = pfs_pkg::irq_width;
  localparam int MW = RW + TW + TW + OW;

  typedef struct packed {
    logic [31:0]   rdata;
    logic          slverr;
    logic [IW-1:0] irq_status;
    logic [IW-1:0] irq_enable;
    logic          irq_out;
  } pfs_regs_type;

  pfs_regs_type  state_ff;
  pfs_regs_type  nxt_state;

  logic [MW-1:0] mon_raw;
  logic [MW-1:0] mon_sync;
  logic [RW-1:0] rail_set;
  logic [TW-1:0] crit_set;
  logic [TW-1:0] hot_set;
  logic [OW-1:0] oc_set;
  logic [RW-1:0] rail_q;
  logic [TW-1:0] crit_q;
  logic [TW-1:0] hot_q;
  logic [OW-1:0] oc_q;
  logic          wr_en;
  logic          rd_en;
  logic          hit_rail;
  logic          hit_crit;
  logic          hit_hot;
  logic          hit_oc;
  logic          hit_ista;
  logic          hit_ien;
  logic          hit_iclr;
  logic          mapped;
  logic          lane0;

  // Register index compare on a word address
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:pfs_pkg::addr_shift] == 10'(idx)) && (a[1:0] == 2'h0);
  endfunction : hit

  // Gather monitor pins in register bit order
  always_comb
  begin
    mon_raw = '0;
    mon_raw[pfs_pkg::bit_ldo_a_one]      = ldo_a_one_fault;
    mon_raw[pfs_pkg::bit_termination]    = termination_ldo_fault;
    mon_raw[pfs_pkg::bit_switcher_b_two] = switcher_b_two_fault;
    mon_raw[pfs_pkg::bit_switcher_b_one] = switcher_b_one_fault;
    mon_raw[pfs_pkg::bit_ldo_a_three]    = ldo_a_three_fault;
    mon_raw[RW + pfs_pkg::bit_die_rest]     = die_rest_critical;
    mon_raw[RW + pfs_pkg::bit_term_ldo]     = termination_critical;
    mon_raw[RW + pfs_pkg::bit_upper_right]  = upper_right_critical;
    mon_raw[RW + pfs_pkg::bit_upper_left]   = upper_left_critical;
    mon_raw[RW + pfs_pkg::bit_lower_right]  = lower_right_critical;
    mon_raw[RW + TW + pfs_pkg::bit_die_rest]    = die_rest_overheat;
    mon_raw[RW + TW + pfs_pkg::bit_term_ldo]    = termination_overheat;
    mon_raw[RW + TW + pfs_pkg::bit_upper_right] = upper_right_overheat;
    mon_raw[RW + TW + pfs_pkg::bit_upper_left]  = upper_left_overheat;
    mon_raw[RW + TW + pfs_pkg::bit_lower_right] = lower_right_overheat;
    mon_raw[RW + 2*TW + pfs_pkg::bit_ctrl_six] = controller_six_overcurrent;
    mon_raw[RW + 2*TW + pfs_pkg::bit_ctrl_two] = controller_two_overcurrent;
    mon_raw[RW + 2*TW + pfs_pkg::bit_ctrl_one] = controller_one_overcurrent;
  end

  // Monitor levels come from analog comparators
  pfs_sync #(
    .W (MW)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (mon_raw),
    .sync_out (mon_sync)
  );

  assign rail_set = mon_sync[RW-1:0];
  assign crit_set = mon_sync[RW+TW-1:RW];
  assign hot_set  = mon_sync[RW+2*TW-1:RW+TW];
  assign oc_set   = mon_sync[MW-1:RW+2*TW];

  // Bus decode, zero wait state
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign lane0    = pstrb[0];
  assign hit_rail = hit(paddr, pfs_pkg::idx_rail_fault);
  assign hit_crit = hit(paddr, pfs_pkg::idx_critical_temp);
  assign hit_hot  = hit(paddr, pfs_pkg::idx_hot_temp);
  assign hit_oc   = hit(paddr, pfs_pkg::idx_overcurrent);
  assign hit_ista = hit(paddr, pfs_pkg::idx_irq_status);
  assign hit_ien  = hit(paddr, pfs_pkg::idx_irq_enable);
  assign hit_iclr = hit(paddr, pfs_pkg::idx_irq_clear);
  assign mapped   = hit_rail | hit_crit | hit_hot | hit_oc | hit_ista | hit_ien | hit_iclr;

  // Sticky flag groups, write one clears only with lane zero strobed
  pfs_flags #(
    .W (RW)
  ) u_rail (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_in   (rail_set),
    .clr_en   (wr_en && hit_rail && lane0),
    .clr_mask (pwdata[RW-1:0]),
    .flags    (rail_q)
  );

  pfs_flags #(
    .W (TW)
  ) u_crit (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_in   (crit_set),
    .clr_en   (wr_en && hit_crit && lane0),
    .clr_mask (pwdata[TW-1:0]),
    .flags    (crit_q)
  );

  pfs_flags #(
    .W (TW)
  ) u_hot (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_in   (hot_set),
    .clr_en   (wr_en && hit_hot && lane0),
    .clr_mask (pwdata[TW-1:0]),
    .flags    (hot_q)
  );

  pfs_flags #(
    .W (OW)
  ) u_oc (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_in   (oc_set),
    .clr_en   (wr_en && hit_oc && lane0),
    .clr_mask (pwdata[OW-1:0]),
    .flags    (oc_q)
  );

  // Read data, interrupt status and enable
  always_comb
  begin
    logic [IW-1:0] evt;
    evt = '0;
    nxt_state = state_ff;
    evt[pfs_pkg::irq_rail] = |rail_set;
    evt[pfs_pkg::irq_crit] = |crit_set;
    evt[pfs_pkg::irq_hot]  = |hot_set;
    evt[pfs_pkg::irq_oc]   = |oc_set;
    // Set wins over clear
    if (wr_en && hit_iclr && lane0)
      nxt_state.irq_status = state_ff.irq_status & ~pwdata[IW-1:0];
    nxt_state.irq_status = nxt_state.irq_status | evt;
    if (wr_en && hit_ien && lane0)
      nxt_state.irq_enable = pwdata[IW-1:0];
    nxt_state.irq_out = |(nxt_state.irq_status & nxt_state.irq_enable);
    // Reserved bits read zero
    if (rd_en)
    begin
      nxt_state.rdata = 32'h0000_0000;
      if (hit_rail)
        nxt_state.rdata[RW-1:0] = rail_q;
      if (hit_crit)
        nxt_state.rdata[TW-1:0] = crit_q;
      if (hit_hot)
        nxt_state.rdata[TW-1:0] = hot_q;
      if (hit_oc)
        nxt_state.rdata[OW-1:0] = oc_q;
      if (hit_ista)
        nxt_state.rdata[IW-1:0] = state_ff.irq_status;
      if (hit_ien)
        nxt_state.rdata[IW-1:0] = state_ff.irq_enable;
    end
    if (psel && !penable)
      nxt_state.slverr = !mapped;
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff            <= '0;
      state_ff.rdata      <= {24'h000000, pfs_pkg::flag_reset};
    end
    else
      state_ff <= nxt_state;
  end

  assign prdata  = state_ff.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && state_ff.slverr;
  assign irq     = state_ff.irq_out;

  // Checks
  crit_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_crit && lane0 && pwdata[0] && !crit_set[0]) |=> !crit_q[0])
    else $error("critical flag not cleared");
  rail_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rail_q[4] && !(wr_en && hit_rail && lane0 && pwdata[4])) |=> rail_q[4])
    else $error("rail flag lost");
  zero_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_hot && !pwdata[2] && hot_q[2]) |=> hot_q[2])
    else $error("zero write cleared hot flag");
  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    oc_set[1] |=> oc_q[1])
    else $error("present overcurrent not flagged");
  pin_latency_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ldo_a_one_fault [*3]) |=> rail_q[4])
    else $error("rail fault not captured");
  crit_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && hit_crit) |=> (prdata[7:5] == 3'h0 && prdata[4:0] == $past(crit_q)))
    else $error("critical read mismatch");
  oc_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && hit_oc) |=> (prdata[7:3] == 5'h00))
    else $error("overcurrent reserved bits set");
  hot_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(hot_q[3]) |-> ##1 (hot_q[3] || $past(wr_en && hit_hot && pwdata[3])))
    else $error("hot flag dropped");

  // Write one clears a flag whose condition has gone
  rail_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_rail && lane0 && pwdata[0] && !rail_set[0]) |=> !rail_q[0])
    else $error("rail flag not cleared");
  hot_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_hot && lane0 && pwdata[4] && !hot_set[4]) |=> !hot_q[4])
    else $error("hot flag not cleared");
  oc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_oc && lane0 && pwdata[2] && !oc_set[2]) |=> !oc_q[2])
    else $error("overcurrent flag not cleared");

  // Writes of zero or without lane zero keep flags
  rail_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_rail && lane0 && !pwdata[0] && rail_q[0]) |=> rail_q[0])
    else $error("zero write cleared rail flag");
  strobe_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_crit && !lane0 && crit_q[3]) |=> crit_q[3])
    else $error("unstrobed write cleared critical flag");

  // Present conditions reach their own flag bit
  rail_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    rail_set[0] |=> rail_q[0])
    else $error("rail condition not flagged");
  crit_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    crit_set[4] |=> crit_q[4])
    else $error("critical condition not flagged");
  corner_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    crit_set[1] |=> crit_q[1])
    else $error("corner condition not flagged");
  hot_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    hot_set[0] |=> hot_q[0])
    else $error("hot condition not flagged");

  // Read data carries flags, with reserved bits checked at zero for rail and hot
  rail_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && hit_rail) |=> (prdata[31:5] == 27'h0 && prdata[4:0] == $past(rail_q)))
    else $error("rail read mismatch");
  hot_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && hit_hot) |=> (prdata[31:5] == 27'h0 && prdata[4:0] == $past(hot_q)))
    else $error("hot read mismatch");
  oc_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && hit_oc) |=> (prdata[2:0] == $past(oc_q)))
    else $error("overcurrent read mismatch");

  // Flags stay at zero while reset is held
  crit_reset_a: assert property (@(posedge pclk)
    !presetn |=> (crit_q == '0))
    else $error("critical flags not reset");
  hot_reset_a: assert property (@(posedge pclk)
    !presetn |=> (hot_q == '0))
    else $error("hot flags not reset");
  oc_reset_a: assert property (@(posedge pclk)
    !presetn |=> (oc_q == '0))
    else $error("overcurrent flags not reset");

  // Interrupt status, enable and error response
  status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|oc_set) |=> state_ff.irq_status[pfs_pkg::irq_oc])
    else $error("overcurrent event not in interrupt status");
  irq_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_iclr && lane0 && pwdata[pfs_pkg::irq_rail] && !(|rail_set))
    |=> !state_ff.irq_status[pfs_pkg::irq_rail])
    else $error("interrupt status not cleared");
  ien_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_ien && lane0) |=> (state_ff.irq_enable == $past(pwdata[IW-1:0])))
    else $error("interrupt enable not written");
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !mapped) |=> state_ff.slverr)
    else $error("unmapped address without error");
  unmapped_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && !mapped) |=> (prdata == 32'h0000_0000))
    else $error("unmapped read not zero");
endmodule : pfs_fault_regs
`default_nettype wire

// ==== pfs_fault_regs_tb.sv ====
// Self-checking testbench for the fault status register bank
`timescale 1ns/100ps
`default_nettype none
module pfs_fault_regs_tb;
  // One row per flag group: monitor position, width, register, summary bit
  typedef struct packed {
    logic [7:0] idx;
    int         lo;
    int         w;
    int         irqb;
  } pfs_row_type;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [17:0] mon;
  logic [31:0] rdat;
  logic        rerr;
  int          num_errors;
  int          checks;
  pfs_row_type rows [4];

  pfs_fault_regs dut (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .psel                       (psel),
    .penable                    (penable),
    .pwrite                     (pwrite),
    .paddr                      (paddr),
    .pwdata                     (pwdata),
    .pstrb                      (pstrb),
    .prdata                     (prdata),
    .pready                     (pready),
    .pslverr                    (pslverr),
    .ldo_a_one_fault            (mon[17]),
    .termination_ldo_fault      (mon[16]),
    .switcher_b_two_fault       (mon[15]),
    .switcher_b_one_fault       (mon[14]),
    .ldo_a_three_fault          (mon[13]),
    .die_rest_critical          (mon[12]),
    .termination_critical       (mon[11]),
    .upper_right_critical       (mon[10]),
    .upper_left_critical        (mon[9]),
    .lower_right_critical       (mon[8]),
    .die_rest_overheat          (mon[7]),
    .termination_overheat       (mon[6]),
    .upper_right_overheat       (mon[5]),
    .upper_left_overheat        (mon[4]),
    .lower_right_overheat       (mon[3]),
    .controller_six_overcurrent (mon[2]),
    .controller_two_overcurrent (mon[1]),
    .controller_one_overcurrent (mon[0]),
    .irq                        (irq)
  );

  // Free running clock, 8 ns period
  always #4 pclk = ~pclk;

  // Byte address from register index
  function automatic logic [11:0] ba(input logic [7:0] idx);
    ba = 12'({idx, 2'b00});
  endfunction : ba

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] st);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      num_errors++;
      $display("mismatch at %0t: no pready", $time);
      conclude();
    end
    else
    begin
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, ba(idx), d, 4'hf);
  endtask : wr

  // Read a register and compare, expecting no error response
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, ba(idx), 32'h0, 4'hf);
    check({31'h0, rerr}, 32'h0);
    check(rdat, exp);
  endtask : rd_chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_clk

  // Main sequence
  initial
  begin
    logic [31:0] msk;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    mon = 18'h0;
    num_errors = 0;
    checks = 0;
    rows[0] = '{pfs_pkg::idx_rail_fault, 13, pfs_pkg::rail_width, pfs_pkg::irq_rail};
    rows[1] = '{pfs_pkg::idx_critical_temp, 8, pfs_pkg::temp_width, pfs_pkg::irq_crit};
    rows[2] = '{pfs_pkg::idx_hot_temp, 3, pfs_pkg::temp_width, pfs_pkg::irq_hot};
    rows[3] = '{pfs_pkg::idx_overcurrent, 0, pfs_pkg::oc_width, pfs_pkg::irq_oc};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wr(pfs_pkg::idx_irq_enable, 32'hf);
    // Each monitor input sets its own sticky bit only
    for (int g = 0; g < 4; g++)
    begin
      for (int b = 0; b < rows[g].w; b++)
      begin
        mon <= 18'h1 << (rows[g].lo + b);
        wait_clk(5);
        mon <= 18'h0;
        wait_clk(4);
        rd_chk(rows[g].idx, 32'h1 << b);
        wr(rows[g].idx, 32'h0);
        rd_chk(rows[g].idx, 32'h1 << b);
        apb(1'b1, ba(rows[g].idx), 32'h1 << b, 4'he);
        rd_chk(rows[g].idx, 32'h1 << b);
        wr(rows[g].idx, 32'h1 << b);
        rd_chk(rows[g].idx, 32'h0);
      end
      check({31'h0, irq}, 32'h1);
      rd_chk(pfs_pkg::idx_irq_status, 32'h1 << rows[g].irqb);
      wr(pfs_pkg::idx_irq_clear, 32'h1 << rows[g].irqb);
      wait_clk(2);
      check({31'h0, irq}, 32'h0);
      rd_chk(pfs_pkg::idx_irq_status, 32'h0);
    end
    // Present conditions win over clear; reserved bits stay zero
    mon <= 18'h3ffff;
    wait_clk(5);
    for (int g = 0; g < 4; g++)
    begin
      msk = (32'h1 << rows[g].w) - 32'h1;
      wr(rows[g].idx, 32'hff);
      rd_chk(rows[g].idx, msk);
    end
    mon <= 18'h0;
    wait_clk(4);
    for (int g = 0; g < 4; g++)
    begin
      msk = (32'h1 << rows[g].w) - 32'h1;
      wr(rows[g].idx, 32'hff ^ msk);
      rd_chk(rows[g].idx, msk);
    end
    // Reset in mid-run with flags set
    presetn <= 1'b0;
    wait_clk(2);
    check({31'h0, irq}, 32'h0);
    presetn <= 1'b1;
    for (int g = 0; g < 4; g++)
      rd_chk(rows[g].idx, {24'h0, pfs_pkg::flag_reset});
    rd_chk(pfs_pkg::idx_irq_enable, 32'h0);
    rd_chk(pfs_pkg::idx_irq_status, 32'h0);
    // Unmapped and misaligned addresses
    apb(1'b0, 12'h2e0, 32'h0, 4'hf);
    check({31'h0, rerr}, 32'h1);
    check(rdat, 32'h0);
    apb(1'b0, ba(pfs_pkg::idx_critical_temp) + 12'h1, 32'h0, 4'hf);
    check({31'h0, rerr}, 32'h1);
    // Masked event holds irq low until enabled
    mon <= 18'h1;
    wait_clk(5);
    mon <= 18'h0;
    check({31'h0, irq}, 32'h0);
    rd_chk(pfs_pkg::idx_overcurrent, 32'h1);
    rd_chk(pfs_pkg::idx_irq_status, 32'h8);
    wr(pfs_pkg::idx_irq_enable, 32'h8);
    wait_clk(2);
    check({31'h0, irq}, 32'h1);
    wr(pfs_pkg::idx_overcurrent, 32'h1);
    wr(pfs_pkg::idx_irq_clear, 32'h8);
    wait_clk(2);
    check({31'h0, irq}, 32'h0);
    conclude();
  end
endmodule : pfs_fault_regs_tb
`default_nettype wire

// ==== pfs_flags.sv ====
// Sticky write-one-to-clear flag group, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module pfs_flags #(
  parameter int W = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] set_in,
  input  wire logic         clr_en,
  input  wire logic [W-1:0] clr_mask,
  output logic      [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } pfs_flags_type;

  pfs_flags_type state_ff;
  pfs_flags_type nxt_state;

  // Clear only where a one is written, present condition sets again
  always_comb
  begin
    nxt_state       = state_ff;
    nxt_state.flags = (state_ff.flags & ~(clr_en ? clr_mask : '0)) | set_in;
  end

  // Flag registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign flags = state_ff.flags;
endmodule : pfs_flags
`default_nettype wire

// ==== pfs_pkg.sv ====
// Package with register map, field positions and reset values of the fault status bank
package pfs_pkg;
  // Printed offsets are not all multiples of four: kept as indices
  localparam logic [7:0]  idx_rail_fault     = 8'hb3;
  localparam logic [7:0]  idx_critical_temp  = 8'hb4;
  localparam logic [7:0]  idx_hot_temp       = 8'hb5;
  localparam logic [7:0]  idx_overcurrent    = 8'hb6;
  localparam logic [7:0]  idx_irq_status     = 8'hc0;
  localparam logic [7:0]  idx_irq_enable     = 8'hc1;
  localparam logic [7:0]  idx_irq_clear      = 8'hc2;
  // Byte address is four times the index
  localparam int          addr_shift         = 2;
  localparam int          addr_width         = 12;
  // Flag widths
  localparam int          rail_width         = 5;
  localparam int          temp_width         = 5;
  localparam int          oc_width           = 3;
  localparam int          irq_width          = 4;
  // Reset values
  localparam logic [7:0]  flag_reset         = 8'h00;
  // Rail fault bit positions
  localparam int          bit_ldo_a_one      = 4;
  localparam int          bit_termination    = 3;
  localparam int          bit_switcher_b_two = 2;
  localparam int          bit_switcher_b_one = 1;
  localparam int          bit_ldo_a_three    = 0;
  // Temperature sensor bit positions
  localparam int          bit_die_rest       = 4;
  localparam int          bit_term_ldo       = 3;
  localparam int          bit_upper_right    = 2;
  localparam int          bit_upper_left     = 1;
  localparam int          bit_lower_right    = 0;
  // Overcurrent bit positions
  localparam int          bit_ctrl_six       = 2;
  localparam int          bit_ctrl_two       = 1;
  localparam int          bit_ctrl_one       = 0;
  // Interrupt summary bit positions
  localparam int          irq_rail           = 0;
  localparam int          irq_crit           = 1;
  localparam int          irq_hot            = 2;
  localparam int          irq_oc             = 3;
endpackage : pfs_pkg

// ==== pfs_sync.sv ====
// Two flip-flop synchroniser for a vector of monitor levels
`timescale 1ns/100ps
`default_nettype none
module pfs_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } pfs_sync_type;

  pfs_sync_type state_ff;
  pfs_sync_type nxt_state;

  // Shift chain, first stage feeds only the second
  always_comb
  begin
    nxt_state        = state_ff;
    nxt_state.stage1 = async_in;
    nxt_state.stage2 = state_ff.stage1;
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign sync_out = state_ff.stage2;
endmodule : pfs_sync
`default_nettype wire
